/* design/flash_seq_map.svh */
// Purpose: Offsets, field positions, command patterns and timing counts
// Assumes: 25 MHz aclk
// Notes: Byte addresses on the AXI4-Lite register bus
`ifndef FLASH_SEQ_MAP_SVH
`define FLASH_SEQ_MAP_SVH
`define CTRL_OFS 8'h00
`define STAT_OFS 8'h04
`define CTRL_SPE 0
`define CTRL_PE 1
`define CTRL_PW 2
`define CTRL_LFS 3
`define CTRL_CLR 4
`define CTRL_IRQ 7
`define STORE_WIN 3'h4
`define LOAD_WIN 3'h3
`define PTR_FUSE_LOW 2'h0
`define PTR_LOCK 2'h1
`define PTR_FUSE_EXT 2'h2
`define PTR_FUSE_HIGH 2'h3
`define CLK_NS 40
`define PROG_TIME_NS 3700000
`define PROG_CYC ((`PROG_TIME_NS + `CLK_NS - 1) / `CLK_NS)
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

/* design/flash_seq_pkg.sv */
// Purpose: Types shared by the self-programming sequencer and its bench
// Assumes: AXI4-Lite with 8-bit byte addresses and 32-bit data
// Notes: Channel signals keep their published names
package flash_seq_pkg;
   typedef struct packed {
      logic awvalid;
      logic [7:0] awaddr;
      logic wvalid;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bready;
      logic arvalid;
      logic [7:0] araddr;
      logic rready;
   } axil_req_t;
   typedef struct packed {
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } axil_rsp_t;
   typedef enum logic [1:0] {OP_IDLE, OP_ERASE, OP_WRITE} op_t;
endpackage

/* design/flash_self_program_sequencer.sv */
// Purpose: Flash self-programming sequencer with lock and fuse readback
// Assumes: store_instr/load_instr and operands come from the core on aclk
// Notes: Registers over AXI4-Lite; eeprom_write_busy is an async pin
`include "flash_seq_map.svh"
module flash_self_program_sequencer
   import flash_seq_pkg::*;
#(
   parameter int PAGE_WORDS = 32,
   parameter int PROG_CYCLES = `PROG_CYC
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire axil_req_t axil_req,
   output axil_rsp_t axil_rsp,
   input wire logic store_instr,
   input wire logic load_instr,
   input wire logic [15:0] ptr,
   input wire logic [15:0] data_word_pair,
   input wire logic global_irq_en,
   input wire logic eeprom_write_busy,
   input wire logic [7:0] lock_prog,
   input wire logic [7:0] fuse_low_prog,
   input wire logic [7:0] fuse_high_prog,
   input wire logic [7:0] fuse_ext_prog,
   output logic cpu_stall,
   output logic prog_ready_irq,
   output logic flash_erase_go,
   output logic flash_write_go,
   output logic [15-$clog2(PAGE_WORDS)-1:0] flash_page,
   input wire logic [$clog2(PAGE_WORDS)-1:0] flash_buf_idx,
   output logic [15:0] flash_buf_data,
   output logic [14:0] flash_rd_addr,
   input wire logic [15:0] flash_rd_data,
   output logic [7:0] load_data,
   output logic load_valid
);
   localparam int WB = $clog2(PAGE_WORDS);
   localparam int PB = 15 - WB;
   localparam int CW = $clog2(PROG_CYCLES + 1);

   // AXI4-Lite slave
   logic aw_full_r, w_full_r, bvalid_r, rvalid_r;
   logic [7:0] aw_addr_r;
   logic [31:0] w_data_r, rdata_r;
   logic [3:0] w_strb_r;
   logic [1:0] bresp_r, rresp_r;
   logic spe_r, pe_r, pw_r, lfs_r, irq_en_r;
   logic [2:0] win_r;
   op_t op_r;
   logic [CW-1:0] cnt_r;
   logic [PAGE_WORDS-1:0] buf_vld_r;
   logic [15:0] buf_mem [PAGE_WORDS];
   logic ee_s1_r, ee_s2_r, ee_s3_r;
   logic ld_pend_r, ld_hi_r, ld_fuse_r;
   logic [1:0] ld_sel_r;

   wire wr_fire = aw_full_r & w_full_r & ~bvalid_r;
   wire wr_ctrl = aw_addr_r == `CTRL_OFS;
   wire wr_ok = wr_ctrl | (aw_addr_r == `STAT_OFS);
   wire rd_ctrl = axil_req.araddr == `CTRL_OFS;
   wire rd_stat = axil_req.araddr == `STAT_OFS;
   wire ar_fire = axil_req.arvalid & ~rvalid_r;
   wire ee_busy = ee_s2_r;
   wire ee_rise = ee_s2_r & ~ee_s3_r;
   wire busy = op_r != OP_IDLE;
   // Control writes are dropped while EEPROM or flash is busy
   wire ctrl_wr = wr_fire & wr_ctrl & w_strb_r[0] & ~ee_busy & ~busy;
   wire armed = spe_r & ~busy;
   wire [2:0] win_lim = lfs_r ? `LOAD_WIN : `STORE_WIN;
   wire win_open = armed & (win_r < win_lim);
   wire store_ok = store_instr & win_open & ~lfs_r & ~ee_busy;
   wire do_erase = store_ok & ~pw_r & pe_r;
   wire do_write = store_ok & pw_r & ~pe_r;
   wire do_load = store_ok & ~pw_r & ~pe_r;
   wire lf_read = load_instr & win_open & lfs_r & ~ee_busy;
   wire expire = armed & (win_r == win_lim - 3'h1) & ~store_ok & ~lf_read;
   wire op_done = busy & (cnt_r == CW'(1));
   wire [WB-1:0] word_idx = ptr[WB:1];
   wire [PB-1:0] page_idx = ptr[15:WB+1];
   wire buf_clr = (ctrl_wr & w_data_r[`CTRL_CLR])
      | (op_done & op_r == OP_WRITE) | ee_rise;
   wire [7:0] ctrl_rd = {irq_en_r, 3'h0, lfs_r, pw_r, pe_r, spe_r};
   wire [7:0] stat_rd = {5'h0, |buf_vld_r, ee_busy, busy};
   wire [7:0] fuse_byte = ld_sel_r == `PTR_LOCK ? lock_prog
      : ld_sel_r == `PTR_FUSE_LOW ? fuse_low_prog
      : ld_sel_r == `PTR_FUSE_HIGH ? fuse_high_prog : fuse_ext_prog;

   assign axil_rsp.awready = ~aw_full_r & ~bvalid_r;
   assign axil_rsp.wready = ~w_full_r & ~bvalid_r;
   assign axil_rsp.bvalid = bvalid_r;
   assign axil_rsp.bresp = bresp_r;
   assign axil_rsp.arready = ~rvalid_r;
   assign axil_rsp.rvalid = rvalid_r;
   assign axil_rsp.rdata = rdata_r;
   assign axil_rsp.rresp = rresp_r;
   assign cpu_stall = busy;
   // Ready only while enable is clear and nothing is running
   assign prog_ready_irq = irq_en_r & global_irq_en & ~spe_r & ~busy & ~ee_busy;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_full_r <= 1'b0;
         w_full_r <= 1'b0;
         bvalid_r <= 1'b0;
         aw_addr_r <= 8'h00;
         w_data_r <= 32'h0;
         w_strb_r <= 4'h0;
         bresp_r <= `RESP_OKAY;
      end else begin
         if (axil_req.awvalid && axil_rsp.awready) begin
            aw_full_r <= 1'b1;
            aw_addr_r <= axil_req.awaddr;
         end
         if (axil_req.wvalid && axil_rsp.wready) begin
            w_full_r <= 1'b1;
            w_data_r <= axil_req.wdata;
            w_strb_r <= axil_req.wstrb;
         end
         if (wr_fire) begin
            aw_full_r <= 1'b0;
            w_full_r <= 1'b0;
            bvalid_r <= 1'b1;
            bresp_r <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
         end else if (bvalid_r && axil_req.bready) begin
            bvalid_r <= 1'b0;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_r <= 1'b0;
         rdata_r <= 32'h0;
         rresp_r <= `RESP_OKAY;
      end else if (ar_fire) begin
         rvalid_r <= 1'b1;
         rdata_r <= {24'h0, rd_ctrl ? ctrl_rd : rd_stat ? stat_rd : 8'h00};
         rresp_r <= (rd_ctrl | rd_stat) ? `RESP_OKAY : `RESP_SLVERR;
      end else if (rvalid_r && axil_req.rready) begin
         rvalid_r <= 1'b0;
      end
   end

   // Pin synchroniser; third stage only feeds the edge detector
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ee_s1_r <= 1'b0;
         ee_s2_r <= 1'b0;
         ee_s3_r <= 1'b0;
      end else begin
         ee_s1_r <= eeprom_write_busy;
         ee_s2_r <= ee_s1_r;
         ee_s3_r <= ee_s2_r;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         {spe_r, pe_r, pw_r, lfs_r, irq_en_r} <= 5'h0;
         win_r <= 3'h0;
      end else if (ctrl_wr) begin
         spe_r <= w_data_r[`CTRL_SPE];
         pe_r <= w_data_r[`CTRL_PE];
         pw_r <= w_data_r[`CTRL_PW];
         lfs_r <= w_data_r[`CTRL_LFS];
         irq_en_r <= w_data_r[`CTRL_IRQ];
         win_r <= 3'h0;
      end else if (op_done || expire || lf_read || do_load) begin
         {spe_r, pe_r, pw_r, lfs_r} <= 4'h0;
      end else if (armed) begin
         win_r <= win_r + 3'h1;
      end
   end

   // One operation counter serves erase and write; count is the minimum time
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         op_r <= OP_IDLE;
         cnt_r <= '0;
         flash_page <= '0;
         flash_erase_go <= 1'b0;
         flash_write_go <= 1'b0;
      end else begin
         flash_erase_go <= do_erase;
         flash_write_go <= do_write;
         case (op_r)
            OP_IDLE: begin
               if (do_erase || do_write) begin
                  op_r <= do_erase ? OP_ERASE : OP_WRITE;
                  cnt_r <= CW'(PROG_CYCLES);
                  flash_page <= page_idx;
               end
            end
            OP_ERASE, OP_WRITE: begin
               cnt_r <= cnt_r - CW'(1);
               if (op_done) begin
                  op_r <= OP_IDLE;
               end
            end
            default: op_r <= OP_IDLE;
         endcase
      end
   end

   // A second load to a filled word is ignored; the first value stays
   always_ff @(posedge aclk) begin
      if (!aresetn || buf_clr) begin
         buf_vld_r <= '0;
      end else if (do_load && !buf_vld_r[word_idx]) begin
         buf_vld_r[word_idx] <= 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (do_load && !buf_vld_r[word_idx]) begin
         buf_mem[word_idx] <= data_word_pair;
      end
   end

   // Unloaded words program as erased
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         flash_buf_data <= 16'hffff;
      end else begin
         flash_buf_data <= buf_vld_r[flash_buf_idx] ? buf_mem[flash_buf_idx] : 16'hffff;
      end
   end

   // Two-stage load: address out, then byte back from flash or fuses
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ld_pend_r <= 1'b0;
         ld_hi_r <= 1'b0;
         ld_fuse_r <= 1'b0;
         ld_sel_r <= 2'h0;
         flash_rd_addr <= 15'h0;
         load_data <= 8'h00;
         load_valid <= 1'b0;
      end else begin
         ld_pend_r <= load_instr & ~busy;
         ld_hi_r <= ptr[0];
         ld_fuse_r <= lf_read;
         ld_sel_r <= ptr[1:0];
         flash_rd_addr <= ptr[15:1];
         load_valid <= ld_pend_r;
         if (ld_fuse_r) begin
            load_data <= ~fuse_byte;
         end else begin
            load_data <= ld_hi_r ? flash_rd_data[15:8] : flash_rd_data[7:0];
         end
      end
   end

   logic [CW:0] stall_len_r;
   always_ff @(posedge aclk) begin
      if (!aresetn || !busy) begin
         stall_len_r <= '0;
      end else begin
         stall_len_r <= stall_len_r + (CW + 1)'(1);
      end
   end

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   property p_erase; do_erase |=> flash_erase_go && cpu_stall && op_r == OP_ERASE; endproperty
   a_erase: assert property (p_erase) else $error("Erase not started");
   property p_write; do_write |=> flash_write_go && cpu_stall ##1 cpu_stall; endproperty
   a_write: assert property (p_write) else $error("Write not stalled");
   property p_hold; busy && cnt_r > CW'(1) |=> cpu_stall; endproperty
   a_hold: assert property (p_hold) else $error("Stall dropped early");
   property p_len; $fell(cpu_stall) |-> $past(stall_len_r) == (CW + 1)'(PROG_CYCLES - 1); endproperty
   a_len: assert property (p_len) else $error("Operation length wrong");
   // A clear strobe in the same cycle wins over the load
   property p_load; do_load && !buf_vld_r[word_idx] && !buf_clr |=> buf_vld_r[$past(word_idx)];
   endproperty
   a_load: assert property (p_load) else $error("Buffer word not loaded");
   property p_clr; $rose(ee_s2_r) |=> buf_vld_r == '0; endproperty
   a_clr: assert property (p_clr) else $error("Buffer kept over EEPROM write");
   property p_block; ee_busy && store_instr |=> !flash_erase_go && !flash_write_go; endproperty
   a_block: assert property (p_block) else $error("Command during EEPROM write");
   property p_lfto; spe_r && lfs_r && win_r == 3'h2 && !load_instr && !ctrl_wr |=> !lfs_r && !spe_r;
   endproperty
   a_lfto: assert property (p_lfto) else $error("Select not cleared");
   property p_pwto; armed && pw_r && win_r == 3'h3 && !store_instr && !ctrl_wr |=> !pw_r; endproperty
   a_pwto: assert property (p_pwto) else $error("Page write bit stuck");
   property p_lock; lf_read && ptr[1:0] == `PTR_LOCK |-> ##2 load_data == ~$past(lock_prog, 1);
   endproperty
   a_lock: assert property (p_lock) else $error("Lock byte wrong");
   property p_irq; prog_ready_irq |-> !spe_r && !cpu_stall && !ee_busy; endproperty
   a_irq: assert property (p_irq) else $error("Ready raised while busy");

   c_erase: cover property (do_erase ##1 cpu_stall);
   c_write: cover property (do_write);
   c_lfread: cover property (lf_read ##2 load_valid);
endmodule // flash_self_program_sequencer

/* tb/core_model.sv */
// Purpose: Core side: store and load program strobes, plus the flash array
// Assumes: Strobes are one-cycle pulses on aclk
// Notes: Operands go inverted when idle so a stale value never looks live
module core_model (
   input wire logic aclk,
   output logic store_instr,
   output logic load_instr,
   output logic [15:0] ptr,
   output logic [15:0] data_word_pair,
   input wire logic [14:0] flash_rd_addr,
   output logic [15:0] flash_rd_data
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      store_instr = 1'b0;
      load_instr = 1'b0;
      ptr = 16'h0000;
      data_word_pair = 16'h0000;
   end
   // Contents follow the word address, so a wrong address shows up
   assign flash_rd_data = {flash_rd_addr, 1'b1} ^ 16'h5a3c;
   // Callers load each word once per fill and reuse the page
   task automatic strobe(input logic st, input logic [15:0] p, input logic [15:0] d);
      store_instr <= st;
      load_instr <= ~st;
      ptr <= p;
      data_word_pair <= d;
      @(posedge aclk);
      store_instr <= 1'b0;
      load_instr <= 1'b0;
      ptr <= ~p;
      data_word_pair <= ~d;
   endtask
endmodule // core_model

/* tb/tb.sv */
// Purpose: Self-checking bench for the flash self-programming sequencer
// Assumes: PROG_CYCLES shortened to 20
// Notes: Outputs are sampled at the rising edge, before that edge's updates land
`include "flash_seq_map.svh"
module tb import flash_seq_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int PC = 20;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic global_irq_en = 1'b1;
   logic eeprom_write_busy = 1'b0;
   logic [4:0] flash_buf_idx = 5'h00;
   axil_req_t req = '0;
   axil_rsp_t rsp;
   logic store_instr, load_instr, cpu_stall, prog_ready_irq, flash_erase_go, flash_write_go;
   logic load_valid;
   logic [15:0] ptr, data_word_pair, flash_buf_data, flash_rd_data;
   logic [14:0] flash_rd_addr;
   logic [9:0] flash_page;
   logic [7:0] load_data;
   logic [31:0] rd;
   logic [1:0] rs;
   int errors = 0;
   int checked = 0;
   // Control, pointer, expected byte; a select row rewrites control before its load, as each fuse read clears the select
   logic [31:0] rows [7] = '{32'h0900009d, 32'h0000003d, 32'h090001c3, 32'h090002fe,
      32'h09000326, 32'h00123548, 32'h0080023f};
   always #20 aclk = ~aclk;
   flash_self_program_sequencer #(.PROG_CYCLES(PC)) dut (.aclk(aclk), .aresetn(aresetn),
      .axil_req(req), .axil_rsp(rsp), .store_instr(store_instr), .load_instr(load_instr),
      .ptr(ptr), .data_word_pair(data_word_pair), .global_irq_en(global_irq_en),
      .eeprom_write_busy(eeprom_write_busy), .lock_prog(8'h3c), .fuse_low_prog(8'h62),
      .fuse_high_prog(8'hd9), .fuse_ext_prog(8'h01), .cpu_stall(cpu_stall),
      .prog_ready_irq(prog_ready_irq), .flash_erase_go(flash_erase_go),
      .flash_write_go(flash_write_go), .flash_page(flash_page), .flash_buf_idx(flash_buf_idx),
      .flash_buf_data(flash_buf_data), .flash_rd_addr(flash_rd_addr),
      .flash_rd_data(flash_rd_data), .load_data(load_data), .load_valid(load_valid));
   core_model core (.aclk(aclk), .store_instr(store_instr), .load_instr(load_instr),
      .ptr(ptr), .data_word_pair(data_word_pair), .flash_rd_addr(flash_rd_addr),
      .flash_rd_data(flash_rd_data));
   task automatic stop_test;
      $display("compares %0d, mismatches %0d", checked, errors);
      if (errors == 0 && checked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic done(input string s);
      $display("test %s ended, %0d mismatches so far", s, errors);
   endtask
   // Responses are taken at the edge where valid is seen; bready and rready stay high
   task automatic axi(input logic wr, input logic [7:0] a, input logic [31:0] d);
      req.awvalid <= wr;
      req.wvalid <= wr;
      req.arvalid <= ~wr;
      req.awaddr <= a;
      req.araddr <= a;
      req.wdata <= d;
      req.wstrb <= 4'hf;
      for (int n = 0; n < 50; n++) begin
         @(posedge aclk);
         if (rsp.awready) req.awvalid <= 1'b0;
         if (rsp.wready) req.wvalid <= 1'b0;
         if (rsp.arready) req.arvalid <= 1'b0;
         if (wr ? rsp.bvalid : rsp.rvalid) begin
            rd = rsp.rdata;
            rs = wr ? rsp.bresp : rsp.rresp;
            return;
         end
      end
      errors++;
      stop_test();
   endtask
   task automatic ctrl(input logic [7:0] v);
      axi(1'b1, `CTRL_OFS, {24'h000000, v});
   endtask
   task automatic wait_hi(ref logic s);
      for (int n = 0; n < 99 && s !== 1'b1; n++) @(posedge aclk);
      if (s !== 1'b1) begin
         errors++;
         stop_test();
      end
   endtask
   // Buffer read port has one cycle of latency
   task automatic bufchk(input logic [4:0] i, input logic [15:0] e);
      flash_buf_idx <= i;
      repeat (2) @(posedge aclk);
      chk(flash_buf_data, e);
   endtask
   task automatic prog(input logic [7:0] c, input int dly, input logic [15:0] p, ref logic go);
      int n;
      ctrl(c);
      repeat (dly) @(posedge aclk);
      core.strobe(1'b1, p, 16'h0000);
      wait_hi(go);
      chk(flash_page, p[15:6]);
      for (n = 0; n < 99 && cpu_stall === 1'b1; n++) @(posedge aclk);
      chk(n, PC);
   endtask
   initial begin
      req.bready = 1'b1;
      req.rready = 1'b1;
      repeat (12) @(posedge aclk);
      chk(cpu_stall, 0);
      chk(flash_buf_data, 16'hffff);
      aresetn <= 1'b1;
      axi(1'b0, `CTRL_OFS, 0);
      chk(rd, 0);
      chk(rs, `RESP_OKAY);
      axi(1'b1, 8'h08, 1);
      chk(rs, `RESP_SLVERR);
      done("reset and map");
      foreach (rows[i]) begin
         if (rows[i][31:24] != 8'h00) ctrl(rows[i][31:24]);
         core.strobe(1'b0, rows[i][23:8], 16'h0000);
         wait_hi(load_valid);
         chk(load_data, rows[i][7:0]);
      end
      done("load table");
      ctrl(8'h01);
      core.strobe(1'b1, 16'h0246, 16'hbeef);
      ctrl(8'h01);
      core.strobe(1'b1, 16'h0240, 16'h1234);
      bufchk(5'd3, 16'hbeef);
      bufchk(5'd0, 16'h1234);
      axi(1'b0, `STAT_OFS, 0);
      chk(rd, 32'h4);
      // Store lands in the last cycle of the window
      prog(8'h03, 2, 16'h027f, flash_erase_go);
      bufchk(5'd3, 16'hbeef);
      axi(1'b0, `CTRL_OFS, 0);
      chk(rd, 0);
      prog(8'h05, 0, 16'h0240, flash_write_go);
      bufchk(5'd3, 16'hffff);
      done("fill erase write");
      // One cycle past the window: the store must be refused
      ctrl(8'h05);
      repeat (3) @(posedge aclk);
      core.strobe(1'b1, 16'h0240, 16'h0000);
      repeat (2) @(posedge aclk);
      chk(cpu_stall, 0);
      axi(1'b0, `CTRL_OFS, 0);
      chk(rd, 0);
      ctrl(8'h01);
      core.strobe(1'b1, 16'h0242, 16'h7777);
      ctrl(8'h10);
      bufchk(5'd1, 16'hffff);
      ctrl(8'h01);
      core.strobe(1'b1, 16'h0246, 16'habcd);
      eeprom_write_busy <= 1'b1;
      repeat (5) @(posedge aclk);
      bufchk(5'd3, 16'hffff);
      ctrl(8'h09);
      core.strobe(1'b0, 16'h0001, 16'h0000);
      wait_hi(load_valid);
      chk(load_data, 8'h5a);
      axi(1'b0, `STAT_OFS, 0);
      chk(rd, 32'h2);
      eeprom_write_busy <= 1'b0;
      done("expiry clear eeprom");
      repeat (4) @(posedge aclk);
      ctrl(8'h80);
      chk(prog_ready_irq, 1);
      global_irq_en <= 1'b0;
      repeat (2) @(posedge aclk);
      chk(prog_ready_irq, 0);
      ctrl(8'h01);
      core.strobe(1'b1, 16'h0244, 16'h1111);
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      bufchk(5'd2, 16'hffff);
      done("irq and reset");
      // Select set, but the load comes one cycle past its three-cycle window
      ctrl(8'h09);
      repeat (2) @(posedge aclk);
      core.strobe(1'b0, 16'h0000, 16'h0000);
      wait_hi(load_valid);
      chk(load_data, 8'h3d);
      axi(1'b0, `CTRL_OFS, 0);
      chk(rd, 0);
      done("select expiry");
      stop_test();
   end
endmodule // tb
